/* rtl/acs_consts.svh */
// Register map, field positions and timing constants of the converter sequencing block
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_OFF_CTRL0      8'h00
`define ACS_OFF_CTRL1      8'h04
`define ACS_OFF_RES_HIGH   8'h08
`define ACS_OFF_RES_LOW    8'h0C
`define ACS_OFF_STATUS     8'h10

`define ACS_C0_ON          0
`define ACS_C0_GO          1
`define ACS_C0_SEL_LO      2
`define ACS_C0_SEL_HI      6
`define ACS_C1_REF_LO      0
`define ACS_C1_REF_HI      1
`define ACS_C1_CLK_LO      4
`define ACS_C1_CLK_HI      6
`define ACS_C1_JUST        7

`define ACS_CTRL0_MASK     8'h7F
`define ACS_CTRL1_MASK     8'hF3
`define ACS_CTRL_RESET     8'h00

`define ACS_SEL_LAST_EXT   5'h1B
`define ACS_SEL_RSV_A      5'h1C
`define ACS_SEL_RSV_B      5'h1D
`define ACS_SEL_TEMP       5'h1E
`define ACS_SEL_FIXED      5'h1F

`define ACS_CLK_DIV2       3'h0
`define ACS_CLK_DIV8       3'h1
`define ACS_CLK_DIV32      3'h2
`define ACS_CLK_DIV4       3'h4
`define ACS_CLK_DIV16      3'h5
`define ACS_CLK_DIV64      3'h6

`define ACS_REF_SUPPLY     2'h0
`define ACS_REF_RSV        2'h1
`define ACS_REF_PIN        2'h2
`define ACS_REF_FIXED      2'h3

`define ACS_RES_BITS       10
`define ACS_HALF_TICKS     5'h17
`define ACS_SLEEP_WAIT_NS  40
`define ACS_CLK_NS         10
`define ACS_SLEEP_WAIT_CYC ((`ACS_SLEEP_WAIT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`define ACS_RESP_OKAY      2'h0
`define ACS_RESP_SLVERR    2'h2

`endif

/* rtl/acs_pkg.sv */
// Types shared by the converter sequencing block
package acs_pkg;
    typedef enum logic [1:0]
    {
        ACS_IDLE  = 2'b00,
        ACS_DELAY = 2'b01,
        ACS_CONV  = 2'b10
    } acs_state_t;

    typedef struct packed
    {
        logic       ref_valid;
        logic [1:0] pos_ref_select;
        logic       channel_valid;
        logic [4:0] input_selector;
        logic       sel_temp;
        logic       sel_fixed;
    } acs_route_t;
endpackage : acs_pkg

/* rtl/acs_tick_gen.sv */
// Conversion clock tick generator: half-period ticks of the selected clock
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_tick_gen
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [2:0] conv_clock_select,
    input  wire logic       rc_osc_sync,
    output logic            half_tick
);
    logic [5:0] div_cnt_reg;
    logic [5:0] div_cnt_next;
    logic       rc_prev_reg;
    logic       tick_reg;
    logic       tick_next;
    logic [5:0] half_div;

    // Half of the system clock divide ratio
    always_comb
    begin
        case (conv_clock_select)
            `ACS_CLK_DIV2:  half_div = 6'h01;
            `ACS_CLK_DIV4:  half_div = 6'h02;
            `ACS_CLK_DIV8:  half_div = 6'h04;
            `ACS_CLK_DIV16: half_div = 6'h08;
            `ACS_CLK_DIV32: half_div = 6'h10;
            `ACS_CLK_DIV64: half_div = 6'h20;
            default:        half_div = 6'h00;
        endcase
    end

    always_comb
    begin
        div_cnt_next = 6'h00;
        tick_next    = 1'b0;
        if (run)
        begin
            if (conv_clock_select[1:0] == 2'b11)
            begin
                tick_next = rc_osc_sync ^ rc_prev_reg;
            end
            else if (div_cnt_reg + 6'h01 >= half_div)
            begin
                tick_next = 1'b1;
            end
            else
            begin
                div_cnt_next = div_cnt_reg + 6'h01;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_reg <= 6'h00;
            rc_prev_reg <= 1'b0;
            tick_reg    <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_next;
            rc_prev_reg <= rc_osc_sync;
            tick_reg    <= tick_next;
        end
    end

    assign half_tick = tick_reg;
endmodule : acs_tick_gen

/* rtl/acs_top.sv */
// Converter sequencing control with AXI4-Lite register access
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "acs_consts.svh"
// Operation
// - Compare trigger sets start bit and clears the sixteen-bit timer.
// - Five-bit selector in control 0 bits 6..2; 0..27 pick external inputs.
// - Selector codes 28 and 29 connect no channel.
// - Code 30 routes temperature indicator, code 31 the fixed reference.
// - Writing one to bit 1 starts conversion; reads one while busy.
// - Hardware clears the start bit when conversion finishes.
// - Control 0 bit 0 enables converter; zero removes operating current.
// - Right justified: six top bits of high result load as zero.
// - Left justified: six bottom bits of low result load as zero.
// - Clock select divides system clock by 2,4,8,16,32,64 per code.
// - Clock codes 011 and 111 choose dedicated RC oscillator.
// - Reference field: 00 supply, 10 pin, 11 fixed, 01 reserved.
// - Left justified high result holds result bits 9..2.
// - Left justified low result bits 7..6 hold result bits 1..0.
// - Completion clears start bit, sets flag, updates both results.
// - Early clear aborts; unconverted bits copy last converted bit.
// - Full conversion takes eleven and a half conversion clock periods.
// - RC clock delays conversion start by one instruction cycle.
module acs_top
#(
    parameter int SLEEP_WAIT_CYC = `ACS_SLEEP_WAIT_CYC
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    input  wire logic        special_trigger,
    input  wire logic        rc_osc,
    input  wire logic        comparator_out,
    output logic             timer_a_clear,
    output logic             converter_power,
    output logic             sample_hold,
    output logic             dac_bit_valid,
    output logic [9:0]       dac_code,
    output acs_pkg::acs_route_t route,
    output logic             conv_done_irq_flag
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] trig_sync_reg;
    logic [1:0] rc_sync_reg;
    logic [1:0] cmp_sync_reg;
    logic       trig_prev_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_sync_reg <= 2'h0;
            rc_sync_reg   <= 2'h0;
            cmp_sync_reg  <= 2'h0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            trig_sync_reg <= {trig_sync_reg[0], special_trigger};
            rc_sync_reg   <= {rc_sync_reg[0], rc_osc};
            cmp_sync_reg  <= {cmp_sync_reg[0], comparator_out};
            trig_prev_reg <= trig_sync_reg[1];
        end
    end

    logic trig_event;
    assign trig_event = trig_sync_reg[1] & ~trig_prev_reg;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic        aw_held_reg, aw_held_next;
    logic [7:0]  aw_addr_reg, aw_addr_next;
    logic        w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic        w_strb_reg, w_strb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic        wr_fire;
    logic        awready_reg, wready_reg, arready_reg;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `ACS_OFF_CTRL0) || (a == `ACS_OFF_CTRL1) ||
                      (a == `ACS_OFF_RES_HIGH) || (a == `ACS_OFF_RES_LOW) ||
                      (a == `ACS_OFF_STATUS);
    endfunction : addr_mapped

    // ****************************************
    // Register and sequencer state
    // ****************************************
    logic [7:0]  ctrl0_reg, ctrl0_next;
    logic [7:0]  ctrl1_reg, ctrl1_next;
    logic [7:0]  res_high_reg, res_high_next;
    logic [7:0]  res_low_reg, res_low_next;
    logic        flag_reg, flag_next;
    logic        tclr_reg, tclr_next;
    acs_pkg::acs_state_t state_reg, state_next;
    logic [4:0]  half_cnt_reg, half_cnt_next;
    logic [9:0]  sar_reg, sar_next;
    logic [3:0]  bit_idx_reg, bit_idx_next;
    logic [15:0] wait_cnt_reg, wait_cnt_next;
    logic        sh_reg, sh_next;
    logic        half_tick;
    logic        rc_mode;
    logic        load_res;
    logic [9:0]  load_val;

    assign rc_mode = (ctrl1_reg[`ACS_C1_CLK_LO +: 2] == 2'b11);

    acs_tick_gen u_tick
    (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .run               (state_reg == acs_pkg::ACS_CONV),
        .conv_clock_select (ctrl1_reg[`ACS_C1_CLK_HI:`ACS_C1_CLK_LO]),
        .rc_osc_sync       (rc_sync_reg[1]),
        .half_tick         (half_tick)
    );

    // Partial result: unconverted bits copy the last decided bit
    function automatic logic [9:0] fill_partial(input logic [9:0] v, input logic [3:0] idx);
        logic [9:0] r;
        r = v;
        if (idx < 4'd10)
        begin
            for (int i = 0; i < 10; i++)
            begin
                if (i < idx)
                begin
                    r[i] = v[idx];
                end
            end
        end
        fill_partial = r;
    endfunction : fill_partial

    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg & ~s_axil_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg & ~s_axil_rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axil_awvalid && !aw_held_reg)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axil_awaddr;
        end
        if (s_axil_wvalid && !w_held_reg)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axil_wdata;
            w_strb_next = s_axil_wstrb[0];
        end
        wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
        if (wr_fire)
        begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = addr_mapped(aw_addr_reg) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
        end
        if (s_axil_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = addr_mapped(s_axil_araddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
            case (s_axil_araddr)
                `ACS_OFF_CTRL0:    rdata_next = {24'h000000, ctrl0_reg};
                `ACS_OFF_CTRL1:    rdata_next = {24'h000000, ctrl1_reg};
                `ACS_OFF_RES_HIGH: rdata_next = {24'h000000, res_high_reg};
                `ACS_OFF_RES_LOW:  rdata_next = {24'h000000, res_low_reg};
                `ACS_OFF_STATUS:   rdata_next = {31'h00000000, flag_reg};
                default:           rdata_next = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Sequencer and register updates
    // ****************************************
    always_comb
    begin
        ctrl0_next    = ctrl0_reg;
        ctrl1_next    = ctrl1_reg;
        res_high_next = res_high_reg;
        res_low_next  = res_low_reg;
        flag_next     = flag_reg;
        tclr_next     = 1'b0;
        state_next    = state_reg;
        half_cnt_next = half_cnt_reg;
        sar_next      = sar_reg;
        bit_idx_next  = bit_idx_reg;
        wait_cnt_next = wait_cnt_reg;
        sh_next       = 1'b0;
        load_res      = 1'b0;
        load_val      = sar_reg;
        if (wr_fire && w_strb_reg)
        begin
            case (aw_addr_reg)
                `ACS_OFF_CTRL0:    ctrl0_next = w_data_reg[7:0] & `ACS_CTRL0_MASK;
                `ACS_OFF_CTRL1:    ctrl1_next = w_data_reg[7:0] & `ACS_CTRL1_MASK;
                `ACS_OFF_RES_HIGH: res_high_next = w_data_reg[7:0];
                `ACS_OFF_RES_LOW:  res_low_next = w_data_reg[7:0];
                `ACS_OFF_STATUS:   flag_next = flag_reg & ~w_data_reg[0];
                default:           ctrl0_next = ctrl0_reg;
            endcase
        end
        if (trig_event)
        begin
            ctrl0_next[`ACS_C0_GO] = 1'b1;
            tclr_next = 1'b1;
        end
        case (state_reg)
            acs_pkg::ACS_IDLE:
            begin
                if (ctrl0_next[`ACS_C0_GO] && ctrl0_next[`ACS_C0_ON])
                begin
                    wait_cnt_next = 16'h0000;
                    sar_next      = 10'h000;
                    bit_idx_next  = 4'd10;
                    half_cnt_next = 5'h00;
                    state_next    = rc_mode ? acs_pkg::ACS_DELAY : acs_pkg::ACS_CONV;
                end
                else
                begin
                    ctrl0_next[`ACS_C0_GO] = 1'b0;
                end
            end
            acs_pkg::ACS_DELAY:
            begin
                wait_cnt_next = wait_cnt_reg + 16'h0001;
                if (wait_cnt_reg + 16'h0001 >= 16'(SLEEP_WAIT_CYC))
                begin
                    state_next = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV:
            begin
                sh_next = (half_cnt_reg < 5'h02);
                if (half_tick)
                begin
                    half_cnt_next = half_cnt_reg + 5'h01;
                    // Bit decisions on every second half period after sampling
                    if (half_cnt_reg >= 5'h02 && half_cnt_reg[0] && bit_idx_reg != 4'd0)
                    begin
                        sar_next[bit_idx_reg - 4'd1] = cmp_sync_reg[1];
                        bit_idx_next = bit_idx_reg - 4'd1;
                    end
                    if (half_cnt_reg + 5'h01 >= `ACS_HALF_TICKS)
                    begin
                        load_res   = 1'b1;
                        state_next = acs_pkg::ACS_IDLE;
                        ctrl0_next[`ACS_C0_GO] = 1'b0;
                    end
                end
            end
            default:
            begin
                state_next = acs_pkg::ACS_IDLE;
            end
        endcase
        if (state_reg != acs_pkg::ACS_IDLE && !load_res &&
            (!ctrl0_next[`ACS_C0_GO] || !ctrl0_next[`ACS_C0_ON]))
        begin
            load_res   = 1'b1;
            load_val   = fill_partial(sar_reg, bit_idx_reg);
            state_next = acs_pkg::ACS_IDLE;
            ctrl0_next[`ACS_C0_GO] = 1'b0;
        end
        if (load_res)
        begin
            flag_next = 1'b1;
            if (ctrl1_reg[`ACS_C1_JUST])
            begin
                res_high_next = {6'h00, load_val[9:8]};
                res_low_next  = load_val[7:0];
            end
            else
            begin
                res_high_next = load_val[9:2];
                res_low_next  = {load_val[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg  <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            arready_reg  <= 1'b1;
            aw_addr_reg  <= 8'h00;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= `ACS_RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= `ACS_RESP_OKAY;
            ctrl0_reg    <= `ACS_CTRL_RESET;
            ctrl1_reg    <= `ACS_CTRL_RESET;
            res_high_reg <= 8'h00;
            res_low_reg  <= 8'h00;
            flag_reg     <= 1'b0;
            tclr_reg     <= 1'b0;
            state_reg    <= acs_pkg::ACS_IDLE;
            half_cnt_reg <= 5'h00;
            sar_reg      <= 10'h000;
            bit_idx_reg  <= 4'd0;
            wait_cnt_reg <= 16'h0000;
            sh_reg       <= 1'b0;
        end
        else
        begin
            aw_held_reg  <= aw_held_next;
            awready_reg  <= !aw_held_next;
            wready_reg   <= !w_held_next;
            arready_reg  <= !rvalid_next;
            aw_addr_reg  <= aw_addr_next;
            w_held_reg   <= w_held_next;
            w_data_reg   <= w_data_next;
            w_strb_reg   <= w_strb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
            ctrl0_reg    <= ctrl0_next;
            ctrl1_reg    <= ctrl1_next;
            res_high_reg <= res_high_next;
            res_low_reg  <= res_low_next;
            flag_reg     <= flag_next;
            tclr_reg     <= tclr_next;
            state_reg    <= state_next;
            half_cnt_reg <= half_cnt_next;
            sar_reg      <= sar_next;
            bit_idx_reg  <= bit_idx_next;
            wait_cnt_reg <= wait_cnt_next;
            sh_reg       <= sh_next;
        end
    end

    // ****************************************
    // Analog side controls
    // ****************************************
    logic                dac_valid_reg;
    acs_pkg::acs_route_t route_reg;
    logic [4:0]          sel;

    assign sel = ctrl0_reg[`ACS_C0_SEL_HI:`ACS_C0_SEL_LO];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dac_valid_reg <= 1'b0;
            route_reg     <= '0;
        end
        else
        begin
            dac_valid_reg            <= (state_reg == acs_pkg::ACS_CONV);
            route_reg.channel_valid  <= (sel <= `ACS_SEL_LAST_EXT);
            route_reg.input_selector <= sel;
            route_reg.sel_temp       <= (sel == `ACS_SEL_TEMP);
            route_reg.sel_fixed      <= (sel == `ACS_SEL_FIXED);
            route_reg.pos_ref_select <= ctrl1_reg[`ACS_C1_REF_HI:`ACS_C1_REF_LO];
            route_reg.ref_valid      <= (ctrl1_reg[`ACS_C1_REF_HI:`ACS_C1_REF_LO] != `ACS_REF_RSV);
        end
    end

    // Trial code: decided bits, current trial bit set
    logic [9:0] trial_code;
    always_comb
    begin
        trial_code = sar_reg;
        if (bit_idx_reg != 4'd0 && bit_idx_reg <= 4'd10)
        begin
            trial_code[bit_idx_reg - 4'd1] = 1'b1;
        end
    end

    logic [9:0] dac_code_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dac_code_reg <= 10'h000;
        end
        else
        begin
            dac_code_reg <= trial_code;
        end
    end

    assign s_axil_awready     = awready_reg;
    assign s_axil_wready      = wready_reg;
    assign s_axil_bvalid      = bvalid_reg;
    assign s_axil_bresp       = bresp_reg;
    assign s_axil_arready     = arready_reg;
    assign s_axil_rvalid      = rvalid_reg;
    assign s_axil_rdata       = rdata_reg;
    assign s_axil_rresp       = rresp_reg;
    assign timer_a_clear      = tclr_reg;
    assign converter_power    = ctrl0_reg[`ACS_C0_ON];
    assign sample_hold        = sh_reg;
    assign dac_bit_valid      = dac_valid_reg;
    assign dac_code           = dac_code_reg;
    assign route              = route_reg;
    assign conv_done_irq_flag = flag_reg;
endmodule : acs_top

/* verification/acs_adc_asserts.sv */
// Port checker of the converter sequencing block
`timescale 1ns/1ns
module acs_adc_asserts
(
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                special_trigger,
    input wire logic                timer_a_clear,
    input wire logic                converter_power,
    input wire logic                dac_bit_valid,
    input wire logic                sample_hold,
    input wire logic                conv_done_irq_flag,
    input wire logic                s_axil_bvalid,
    input wire logic                s_axil_bready,
    input wire acs_pkg::acs_route_t route
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_trig; $rose(special_trigger) |-> ##[1:5] timer_a_clear; endproperty
    a_trig: assert property (p_trig) else $error("no timer clear");
    property p_pulse; timer_a_clear |=> !timer_a_clear; endproperty
    a_pulse: assert property (p_pulse) else $error("long timer clear");
    property p_ext; route.channel_valid |-> route.input_selector <= 5'h1B; endproperty
    a_ext: assert property (p_ext) else $error("bad channel");
    property p_rsv; route.input_selector inside {5'h1C, 5'h1D}
        |-> !(route.channel_valid | route.sel_temp | route.sel_fixed); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved routed");
    property p_int; (route.sel_temp |-> route.input_selector == 5'h1E)
        and (route.sel_fixed |-> route.input_selector == 5'h1F); endproperty
    a_int: assert property (p_int) else $error("bad internal");
    property p_ref; route.ref_valid |-> route.pos_ref_select != 2'h1; endproperty
    a_ref: assert property (p_ref) else $error("reserved ref");
    property p_len; $rose(dac_bit_valid) |-> dac_bit_valid [*8]; endproperty
    a_len: assert property (p_len) else $error("short conversion");
    property p_done; $fell(dac_bit_valid) |-> ##[0:3] conv_done_irq_flag; endproperty
    a_done: assert property (p_done) else $error("no done flag");
    property p_sh; $rose(dac_bit_valid) |-> sample_hold; endproperty
    a_sh: assert property (p_sh) else $error("no sampling phase");
    property p_pwr; $fell(converter_power) |-> ##[0:3] !dac_bit_valid; endproperty
    a_pwr: assert property (p_pwr) else $error("runs unpowered");
    property p_bh; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("response dropped");
    c_conv: cover property ($rose(dac_bit_valid));
    c_trig: cover property (timer_a_clear);
    c_off: cover property ($fell(converter_power));
endmodule : acs_adc_asserts
bind acs_top acs_adc_asserts u_chk (.*);

/* verification/test_adc_sequencing_control.sv */
// Self-checking testbench of the converter sequencing block
`timescale 1ns/1ns
module test_adc_sequencing_control;
    logic aclk = 0, aresetn = 0, special_trigger = 0, rc_osc = 0, comparator_out = 1;
    logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
    logic [31:0] s_axil_wdata = 0, s_axil_rdata, rd;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic s_axil_arvalid = 0, s_axil_rready = 0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic timer_a_clear, converter_power, sample_hold, dac_bit_valid, conv_done_irq_flag;
    logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
    logic [9:0] dac_code;
    logic [2:0] dv[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    acs_pkg::acs_route_t route;
    int errors = 0, samples_checked = 0, cycles = 0, t0, n, prev, k;
    acs_top #(.SLEEP_WAIT_CYC(1)) dut (.*);
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles % 3 == 0) rc_osc <= ~rc_osc;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    task conclude;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1;
        s_axil_wvalid <= 1;
        s_axil_bready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 0;
            if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 0;
        end
        while (!s_axil_bvalid);
        s_axil_bready <= 0;
        @(posedge aclk);
    endtask : wr
    task rdr(input logic [7:0] a);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1;
        s_axil_rready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 0;
        end
        while (!s_axil_rvalid);
        rd = s_axil_rdata;
        rsp = s_axil_rresp;
        s_axil_rready <= 0;
        @(posedge aclk);
    endtask : rdr
    task conv(input logic [7:0] c1);
        wr(8'h04, {24'h0, c1});
        wr(8'h00, 32'h01);
        t0 = cycles;
        wr(8'h00, 32'h03);
        do rdr(8'h00); while (rd[1] === 1'b1);
        n = cycles - t0;
    endtask : conv
    task res(input logic [7:0] h, input logic [7:0] l);
        rdr(8'h08);
        check(rd, h);
        rdr(8'h0C);
        check(rd, l);
        rdr(8'h10);
        check(rd, 1);
        wr(8'h10, 1);
    endtask : res
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(8'h00);
        check(rd, 0);
        rdr(8'h04);
        check(rd, 0);
        wr(8'h00, 32'hFC);
        rdr(8'h00);
        check(rd, 32'h7C);
        check(route.sel_fixed, 1);
        wr(8'h04, 32'hFF);
        rdr(8'h04);
        check(rd, 32'hF3);
        rdr(8'h14);
        check(rsp, 2);
        check(rd, 0);
        for (int c = 27; c < 32; c++)
        begin
            wr(8'h00, c << 2);
            rdr(8'h00);
            check(route.channel_valid, c < 28);
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h04, r);
            rdr(8'h04);
            check(route.ref_valid, r != 1);
        end
        wr(8'h00, 32'h02);
        rdr(8'h00);
        check(rd, 0);
        prev = 0;
        foreach (dv[i])
        begin
            conv({1'b1, dv[i], 4'h0});
            check(n > prev, 1);
            check(dac_code, 10'h3FF);
            prev = n;
            res(8'h03, 8'hFF);
        end
        conv(8'h00);
        check(converter_power, 1);
        res(8'hFF, 8'hC0);
        for (int c = 3; c < 8; c += 4)
        begin
            conv({1'b1, c[2:0], 4'h0});
            res(8'h03, 8'hFF);
        end
        wr(8'h00, 32'h01);
        special_trigger <= 1;
        k = 0;
        repeat (8)
        begin
            @(posedge aclk);
            if (timer_a_clear === 1'b1) k++;
        end
        special_trigger <= 0;
        check(k, 1);
        rdr(8'h00);
        check(rd[1], 1);
        do rdr(8'h00); while (rd[1] === 1'b1);
        res(8'h03, 8'hFF);
        wr(8'h04, 32'hE0);
        comparator_out <= 0;
        wr(8'h00, 32'h03);
        repeat (160) @(posedge aclk);
        comparator_out <= 1;
        repeat (40) @(posedge aclk);
        wr(8'h00, 32'h01);
        res(8'h01, 8'hFF);
        check(dac_bit_valid, 0);
        wr(8'h00, 0);
        conclude();
    end
endmodule : test_adc_sequencing_control
